// ---- dv/art_timer_capture_tb.sv ----
/*
 * Self-checking bench for the auto-reload timer with capture.
 * Assumes art_pkg and art_timer_capture are compiled first; one aclk.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            error_cnt++; \
            $display("mismatch %s expected %0h seen %0h", nm, exp, got); \
        end \
    end

module art_timer_capture_tb;
    import art_pkg::*;
    // Stimulus and observed signals
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        rtc_clk = 1'b0;
    logic        cmp_out = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        arvalid = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp, wr_resp, rd_resp;
    logic [31:0] rdata;
    logic [7:0]  d;
    logic [7:0]  cap_first;
    logic        ce = 1'b1;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          t_rise = 0;
    int          t_first = 0;

    always #50 aclk = ~aclk;

    // Free edge count, so capture periods are judged against the stimulus
    always @(posedge aclk) cyc <= cyc + 1;

    // Responses always accepted, so bready and rready stay high
    art_timer_capture uut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .rtc_clk(rtc_clk),
        .cmp_out(cmp_out), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(1'b1), .irq(irq));

    // ------------------------------------------------------------------
    // Bus and pin tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        awaddr  <= a;
        wdata   <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        wr_resp = bresp;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        v       = rdata[7:0];
        rd_resp = rresp;
    endtask

    task automatic exp_reg(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        `CHK($sformatf("reg %0h", a), e, v);
        `CHK("read response", RESP_OKAY, rd_resp);
    endtask

    // Irq is registered, so look half a cycle after the edge
    task automatic chk_irq(input logic e);
        @(negedge aclk);
        `CHK("irq", e, irq);
        @(posedge aclk);
    endtask

    // Slow pin pulses, far below aclk so the synchroniser sees each one
    task automatic pulse(input bit cmp, input int n);
        repeat (n) begin
            if (cmp) cmp_out <= 1'b1;
            else rtc_clk <= 1'b1;
            t_rise = cyc;
            repeat (4) @(posedge aclk);
            cmp_out <= 1'b0;
            rtc_clk <= 1'b0;
            repeat (4) @(posedge aclk);
        end
        repeat (6) @(posedge aclk);
    endtask

    task automatic run_stop(input logic [7:0] c);
        wr(OFS_CTRL, c);
        wr(OFS_CTRL, 8'h00);
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        exp_reg(OFS_CTRL, 8'h00);
        exp_reg(OFS_RLD_HI, 8'h00);
        rd(8'h24, d);
        `CHK("unmapped read", RESP_SLVERR, rd_resp);
        wr(OFS_STATUS, 8'h03);
        `CHK("status write", RESP_SLVERR, wr_resp);
        // 16-bit wrap loads the reload pair
        wr(OFS_IRQEN, 8'h01);
        wr(OFS_CNT_LO, 8'hFF);
        wr(OFS_CNT_HI, 8'hFF);
        wr(OFS_RLD_LO, 8'h34);
        wr(OFS_RLD_HI, 8'h12);
        repeat (20) @(posedge aclk);
        exp_reg(OFS_CNT_LO, 8'hFF);
        run_stop(8'h22);
        exp_reg(OFS_CNT_HI, 8'h12);
        repeat (30) @(posedge aclk);
        rd(OFS_STATUS, d);
        `CHK("high flag", 1'b1, d[FLG_HIGH]);
        chk_irq(1'b1);
        wr(OFS_CLEAR, 8'h03);
        chk_irq(1'b0);
        // Low byte wrap alone needs both enables
        wr(OFS_CNT_HI, 8'h00);
        wr(OFS_CNT_LO, 8'hFE);
        run_stop(8'h22);
        exp_reg(OFS_STATUS, 8'h02);
        chk_irq(1'b0);
        wr(OFS_IRQEN, 8'h03);
        chk_irq(1'b1);
        wr(OFS_CLEAR, 8'h03);
        // Split mode, run clear then set
        wr(OFS_CNT_LO, 8'hFE);
        wr(OFS_CNT_HI, 8'hFE);
        wr(OFS_RLD_LO, 8'h50);
        wr(OFS_RLD_HI, 8'h60);
        run_stop(8'h61);
        exp_reg(OFS_CNT_HI, 8'hFE);
        exp_reg(OFS_STATUS, 8'h02);
        rd(OFS_CNT_LO, d);
        `CHK("split low reload", 4'h5, d[7:4]);
        run_stop(8'h63);
        exp_reg(OFS_STATUS, 8'h03);
        rd(OFS_CNT_HI, d);
        `CHK("split high reload", 4'h6, d[7:4]);
        chk_irq(1'b1);
        wr(OFS_CLEAR, 8'h03);
        wr(OFS_IRQEN, 8'h01);
        // Capture on every eighth real-time clock, count held
        wr(OFS_CNT_HI, 8'hAB);
        wr(OFS_CNT_LO, 8'hCD);
        wr(OFS_CTRL, 8'h24);
        pulse(1'b0, 7);
        exp_reg(OFS_STATUS, 8'h00);
        pulse(1'b0, 1);
        exp_reg(OFS_STATUS, 8'h01);
        exp_reg(OFS_RLD_LO, 8'hCD);
        exp_reg(OFS_RLD_HI, 8'hAB);
        chk_irq(1'b1);
        wr(OFS_CLEAR, 8'h03);
        // Fast timer clock; period is the difference of two captures
        wr(OFS_CTRL, 8'h26);
        pulse(1'b0, 8);
        rd(OFS_RLD_LO, cap_first);
        t_first = t_rise;
        pulse(1'b0, 8);
        rd(OFS_RLD_LO, d);
        `CHK("capture period", 8'(t_rise - t_first), 8'(d - cap_first));
        wr(OFS_CTRL, 8'h00);
        wr(OFS_CLEAR, 8'h03);
        // Capture on comparator rising edge
        wr(OFS_CTRL, 8'h34);
        wr(OFS_CNT_HI, 8'h12);
        wr(OFS_CNT_LO, 8'h34);
        pulse(1'b1, 1);
        exp_reg(OFS_RLD_LO, 8'h34);
        exp_reg(OFS_STATUS, 8'h01);
        wr(OFS_CLEAR, 8'h03);
        // External clock sources
        wr(OFS_CTRL, 8'h0A);
        wr(OFS_CNT_LO, 8'h00);
        pulse(1'b0, 16);
        wr(OFS_CTRL, 8'h1A);
        pulse(1'b1, 3);
        wr(OFS_CTRL, 8'h12);
        repeat (50) @(posedge aclk);
        exp_reg(OFS_CNT_LO, 8'h05);
        wr(OFS_CTRL, 8'h02);
        repeat (120) @(posedge aclk);
        wr(OFS_CTRL, 8'h00);
        rd(OFS_CNT_LO, d);
        `CHK("divide by 12", 1'b1, d >= 8'h0F && d <= 8'h10);
        // Same run window twice, the second with ten edges of ce low
        wr(OFS_CNT_LO, 8'h00);
        wr(OFS_CTRL, 8'h22);
        repeat (10) @(posedge aclk);
        wr(OFS_CTRL, 8'h00);
        rd(OFS_CNT_LO, cap_first);
        wr(OFS_CNT_LO, 8'h00);
        wr(OFS_CTRL, 8'h22);
        ce <= 1'b0;
        repeat (10) @(posedge aclk);
        ce <= 1'b1;
        wr(OFS_CTRL, 8'h00);
        rd(OFS_CNT_LO, d);
        `CHK("count frozen by ce", 8'(cap_first - 8'h0A), d);
        complete_run();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #(100 * 20000);
        error_cnt++;
        complete_run();
    end
endmodule

`default_nettype wire

// ---- verilog/art_pkg.sv ----
/*
 * Constants for the auto-reload timer with capture: register map,
 * control field positions, interrupt bit positions and prescale counts.
 * Assumes a 32-bit AXI4-Lite register bus and one system clock.
 */
`default_nettype none

package art_pkg;

    // ------------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;  // timer_control_register
    localparam logic [7:0] OFS_CNT_LO = 8'h04;  // count_low_byte
    localparam logic [7:0] OFS_CNT_HI = 8'h08;  // count_high_byte
    localparam logic [7:0] OFS_RLD_LO = 8'h0C;  // reload_low_byte
    localparam logic [7:0] OFS_RLD_HI = 8'h10;  // reload_high_byte
    localparam logic [7:0] OFS_STATUS = 8'h14;  // overflow flags, read only
    localparam logic [7:0] OFS_CLEAR  = 8'h18;  // write one to clear a flag
    localparam logic [7:0] OFS_IRQEN  = 8'h1C;  // interrupt enables

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTL_SPLIT  = 0;   // split_mode_select
    localparam int CTL_RUN    = 1;   // run_control
    localparam int CTL_CAPEN  = 2;   // capture_enable
    localparam int CTL_XSEL0  = 3;   // external_clock_select, low bit
    localparam int CTL_XSEL1  = 4;   // capture_source_select
    localparam int CTL_LOCLK  = 5;   // low_byte_clock_select
    localparam int CTL_HICLK  = 6;   // high_byte_clock_select
    localparam int CTL_W      = 7;
    localparam logic [6:0] CTL_RESET = 7'h00;

    // ------------------------------------------------------------------
    // Status, clear and enable layout
    // ------------------------------------------------------------------
    localparam int FLG_HIGH  = 0;    // high_overflow_flag / timer_interrupt_enable
    localparam int FLG_LOW   = 1;    // low_overflow_flag / low_byte_irq_enable
    localparam int FLG_W     = 2;

    // ------------------------------------------------------------------
    // External clock select codes, prescale counts, counter limits
    // ------------------------------------------------------------------
    localparam logic [1:0] XSEL_DIV12 = 2'h0;
    localparam logic [1:0] XSEL_RTC8  = 2'h1;
    localparam logic [1:0] XSEL_RSVD  = 2'h2;
    localparam logic [1:0] XSEL_CMP   = 2'h3;
    localparam logic [3:0] DIV12_LAST = 4'hB;   // twelve system clocks
    localparam logic [2:0] RTC8_LAST  = 3'h7;   // eight real-time clocks
    localparam logic [7:0] BYTE_MAX   = 8'hFF;
    localparam logic [7:0] BYTE_ZERO  = 8'h00;

    // ------------------------------------------------------------------
    // AXI responses
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// ---- verilog/art_timer_capture.sv ----
/*
 * Auto-reload timer with capture: 16-bit or split 8-bit counting,
 * period capture, overflow flags and one level interrupt, reached
 * over an AXI4-Lite slave.
 * Assumes rtc_clk and cmp_out are asynchronous pins; everything else
 * runs on aclk. ce low freezes all state.
 */
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module art_timer_capture (
    // Clock, reset, enable
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       ce,
    // Asynchronous clock sources
    input  wire logic                       rtc_clk,
    input  wire logic                       cmp_out,
    // AXI4-Lite write address
    input  wire logic [art_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                       awvalid,
    output logic                            awready,
    // AXI4-Lite write data
    input  wire logic [art_pkg::DATA_W-1:0] wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output logic                            wready,
    // AXI4-Lite write response
    output logic [1:0]                      bresp,
    output logic                            bvalid,
    input  wire logic                       bready,
    // AXI4-Lite read address
    input  wire logic [art_pkg::ADDR_W-1:0] araddr,
    input  wire logic                       arvalid,
    output logic                            arready,
    // AXI4-Lite read data
    output logic [art_pkg::DATA_W-1:0]      rdata,
    output logic [1:0]                      rresp,
    output logic                            rvalid,
    input  wire logic                       rready,
    // Interrupt
    output logic                            irq
);
    import art_pkg::*;

    // ------------------------------------------------------------------
    // Source synchronisers and prescalers
    // ------------------------------------------------------------------
    logic       rtc_s1, rtc_s2, rtc_prev;
    logic       cmp_s1, cmp_s2, cmp_prev;
    logic [3:0] div12_cnt, next_div12_cnt;
    logic [2:0] rtc8_cnt, next_rtc8_cnt;
    logic       tick_div12, tick_rtc8, tick_cmp;

    // Only the second stage feeds the edge detectors
    always_comb begin
        tick_cmp       = cmp_s2 & ~cmp_prev;
        tick_div12     = (div12_cnt == DIV12_LAST);
        next_div12_cnt = tick_div12 ? 4'h0 : div12_cnt + 4'h1;
        tick_rtc8      = (rtc_s2 & ~rtc_prev) & (rtc8_cnt == RTC8_LAST);
        next_rtc8_cnt  = rtc8_cnt;
        if (rtc_s2 & ~rtc_prev) begin
            next_rtc8_cnt = rtc8_cnt + 3'h1;
        end
    end

    // Two flops per pin, a third for the edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rtc_s1    <= 1'b0;
            rtc_s2    <= 1'b0;
            rtc_prev  <= 1'b0;
            cmp_s1    <= 1'b0;
            cmp_s2    <= 1'b0;
            cmp_prev  <= 1'b0;
            div12_cnt <= 4'h0;
            rtc8_cnt  <= 3'h0;
        end else if (ce) begin
            rtc_s1    <= rtc_clk;
            rtc_s2    <= rtc_s1;
            rtc_prev  <= rtc_s2;
            cmp_s1    <= cmp_out;
            cmp_s2    <= cmp_s1;
            cmp_prev  <= cmp_s2;
            div12_cnt <= next_div12_cnt;
            rtc8_cnt  <= next_rtc8_cnt;
        end
    end

    // ------------------------------------------------------------------
    // Register bus slave
    // ------------------------------------------------------------------
    logic              aw_held, next_aw_held, w_held, next_w_held;
    logic [ADDR_W-1:0] aw_addr, next_aw_addr;
    logic [DATA_W-1:0] w_data, next_w_data;
    logic              w_lane0, next_w_lane0;
    logic              next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0]        next_bresp, next_rresp;
    logic [DATA_W-1:0] next_rdata;
    logic              do_write, wr_ok, ar_take;
    logic              wr_ctrl, wr_cnt_lo, wr_cnt_hi, wr_rld_lo, wr_rld_hi, wr_clr, wr_ien;

    // Timer state read back by the bus
    logic [CTL_W-1:0] ctrl, next_ctrl;
    logic [7:0]       cnt_lo, cnt_hi, rld_lo, rld_hi;
    logic [7:0]       next_cnt_lo, next_cnt_hi, next_rld_lo, next_rld_hi;
    logic [FLG_W-1:0] flags, next_flags, ien, next_ien;
    logic             next_irq;

    // Address and data may arrive in either order; answer once both are held
    always_comb begin
        do_write     = aw_held & w_held & ~bvalid;
        ar_take      = arvalid & arready;
        next_aw_held = (aw_held & ~do_write) | (awvalid & awready);
        next_w_held  = (w_held & ~do_write) | (wvalid & wready);
        next_aw_addr = (awvalid & awready) ? awaddr : aw_addr;
        next_w_data  = (wvalid & wready) ? wdata : w_data;
        next_w_lane0 = (wvalid & wready) ? wstrb[0] : w_lane0;
        next_awready = ~next_aw_held;
        next_wready  = ~next_w_held;
        wr_ok        = 1'b1;
        case (aw_addr)
            OFS_CTRL, OFS_CNT_LO, OFS_CNT_HI, OFS_RLD_LO,
            OFS_RLD_HI, OFS_CLEAR, OFS_IRQEN: wr_ok = 1'b1;
            default:                          wr_ok = 1'b0;
        endcase
        // Narrow registers sit in lane 0; other lanes are ignored
        wr_ctrl   = do_write & w_lane0 & (aw_addr == OFS_CTRL);
        wr_cnt_lo = do_write & w_lane0 & (aw_addr == OFS_CNT_LO);
        wr_cnt_hi = do_write & w_lane0 & (aw_addr == OFS_CNT_HI);
        wr_rld_lo = do_write & w_lane0 & (aw_addr == OFS_RLD_LO);
        wr_rld_hi = do_write & w_lane0 & (aw_addr == OFS_RLD_HI);
        wr_clr    = do_write & w_lane0 & (aw_addr == OFS_CLEAR);
        wr_ien    = do_write & w_lane0 & (aw_addr == OFS_IRQEN);
        next_bvalid = (bvalid & ~bready) | do_write;
        next_bresp  = do_write ? (wr_ok ? RESP_OKAY : RESP_SLVERR) : bresp;
        // Read answer is latched at the address handshake
        next_rvalid  = (rvalid & ~rready) | ar_take;
        next_arready = ~next_rvalid;
        next_rdata   = rdata;
        next_rresp   = rresp;
        if (ar_take) begin
            next_rresp = RESP_OKAY;
            case (araddr)
                OFS_CTRL:   next_rdata = {{(DATA_W-CTL_W){1'b0}}, ctrl};
                OFS_CNT_LO: next_rdata = {24'h000000, cnt_lo};
                OFS_CNT_HI: next_rdata = {24'h000000, cnt_hi};
                OFS_RLD_LO: next_rdata = {24'h000000, rld_lo};
                OFS_RLD_HI: next_rdata = {24'h000000, rld_hi};
                OFS_STATUS: next_rdata = {{(DATA_W-FLG_W){1'b0}}, flags};
                OFS_CLEAR:  next_rdata = 32'h00000000;
                OFS_IRQEN:  next_rdata = {{(DATA_W-FLG_W){1'b0}}, ien};
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    // Bus state; outputs come straight from these flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h00000000;
            w_lane0 <= 1'b0;
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= 2'h0;
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= 2'h0;
        end else if (ce) begin
            aw_held <= next_aw_held;
            w_held  <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data  <= next_w_data;
            w_lane0 <= next_w_lane0;
            awready <= next_awready;
            wready  <= next_wready;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            arready <= next_arready;
            rvalid  <= next_rvalid;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
        end
    end

    // ------------------------------------------------------------------
    // Timer core
    // ------------------------------------------------------------------
    logic       split, run, cap_en, lo_system_clock, hi_system_clock;
    logic [1:0] xsel;
    logic       ext_tick, lo_tick, hi_tick, cap_event;
    logic       lo_ovf, hi_ovf;
    logic [FLG_W-1:0] flag_set;

    // Clock choice per byte, then count, reload, capture and flags
    always_comb begin
        split     = ctrl[CTL_SPLIT];
        run       = ctrl[CTL_RUN];
        cap_en    = ctrl[CTL_CAPEN];
        xsel      = {ctrl[CTL_XSEL1], ctrl[CTL_XSEL0]};
        lo_system_clock = ctrl[CTL_LOCLK];
        hi_system_clock = ctrl[CTL_HICLK];
        case (xsel)
            XSEL_DIV12: ext_tick = tick_div12;
            XSEL_RTC8:  ext_tick = tick_rtc8;
            XSEL_RSVD:  ext_tick = 1'b0;                         // Reserved: no clock
            XSEL_CMP:   ext_tick = tick_cmp;
            default:    ext_tick = 1'b0;
        endcase
        lo_tick   = lo_system_clock | ext_tick;
        hi_tick   = hi_system_clock | ext_tick;
        // Upper select bit picks the capture source
        cap_event = cap_en & (ctrl[CTL_XSEL1] ? tick_cmp : tick_rtc8);
        next_cnt_lo = cnt_lo;
        next_cnt_hi = cnt_hi;
        lo_ovf      = 1'b0;
        hi_ovf      = 1'b0;
        if (!split) begin
            // Whole word steps on the low-byte clock while running
            if (run & lo_tick) begin
                lo_ovf = (cnt_lo == BYTE_MAX);
                hi_ovf = lo_ovf & (cnt_hi == BYTE_MAX);
                if (hi_ovf) begin
                    next_cnt_lo = rld_lo;
                    next_cnt_hi = rld_hi;
                end else begin
                    {next_cnt_hi, next_cnt_lo} = {cnt_hi, cnt_lo} + 16'h0001;
                end
            end
        end else begin
            // Low byte free-runs; run bit gates the high byte only
            if (lo_tick) begin
                lo_ovf      = (cnt_lo == BYTE_MAX);
                next_cnt_lo = lo_ovf ? rld_lo : cnt_lo + 8'h01;
            end
            if (run & hi_tick) begin
                hi_ovf      = (cnt_hi == BYTE_MAX);
                next_cnt_hi = hi_ovf ? rld_hi : cnt_hi + 8'h01;
            end
        end
        // Software writes to the count win over counting
        if (wr_cnt_lo) begin
            next_cnt_lo = w_data[7:0];
        end
        if (wr_cnt_hi) begin
            next_cnt_hi = w_data[7:0];
        end
        next_rld_lo = wr_rld_lo ? w_data[7:0] : rld_lo;
        next_rld_hi = wr_rld_hi ? w_data[7:0] : rld_hi;
        // Capture beats a reload write in the same cycle
        if (cap_event) begin
            next_rld_lo = cnt_lo;
            next_rld_hi = cnt_hi;
        end
        flag_set            = '0;
        flag_set[FLG_HIGH]  = hi_ovf | cap_event;
        flag_set[FLG_LOW]   = lo_ovf;
        // Set wins over a clear arriving in the same cycle
        next_flags = (flags & ~(wr_clr ? w_data[FLG_W-1:0] : '0)) | flag_set;
        next_ctrl  = wr_ctrl ? w_data[CTL_W-1:0] : ctrl;
        next_ien   = wr_ien ? w_data[FLG_W-1:0] : ien;
        // Low flag only interrupts with both enables set
        next_irq   = next_ien[FLG_HIGH] & (next_flags[FLG_HIGH] |
                     (next_ien[FLG_LOW] & next_flags[FLG_LOW]));
    end

    // Timer registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl   <= CTL_RESET;
            cnt_lo <= BYTE_ZERO;
            cnt_hi <= BYTE_ZERO;
            rld_lo <= BYTE_ZERO;
            rld_hi <= BYTE_ZERO;
            flags  <= '0;
            ien    <= '0;
            irq    <= 1'b0;
        end else if (ce) begin
            ctrl   <= next_ctrl;
            cnt_lo <= next_cnt_lo;
            cnt_hi <= next_cnt_hi;
            rld_lo <= next_rld_lo;
            rld_hi <= next_rld_hi;
            flags  <= next_flags;
            ien    <= next_ien;
            irq    <= next_irq;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    AST_WORD_RELOAD: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !split && run && lo_tick && {cnt_hi, cnt_lo} == 16'hFFFF
         && !wr_cnt_lo && !wr_cnt_hi)
        |=> ({cnt_hi, cnt_lo} == {$past(rld_hi), $past(rld_lo)}) && flags[FLG_HIGH])
        else $error("16-bit rollover did not reload or set high flag");

    AST_WORD_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !split && !run && !wr_cnt_lo && !wr_cnt_hi && !wr_ctrl)
        |=> $stable({cnt_hi, cnt_lo}))
        else $error("16-bit count moved while stopped");

    AST_WORD_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !split && run && lo_tick && {cnt_hi, cnt_lo} != 16'hFFFF
         && !wr_cnt_lo && !wr_cnt_hi)
        |=> {cnt_hi, cnt_lo} == $past({cnt_hi, cnt_lo}) + 16'h0001)
        else $error("16-bit count did not step by one");

    AST_SPLIT_LOW_FREE: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && split && !run && lo_tick && cnt_lo != BYTE_MAX && !wr_cnt_lo && !wr_cnt_hi)
        |=> (cnt_lo == $past(cnt_lo) + 8'h01) && $stable(cnt_hi))
        else $error("split low byte not free running or high byte moved");

    AST_SPLIT_LOW_RELOAD: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && split && lo_tick && cnt_lo == BYTE_MAX && !wr_cnt_lo)
        |=> cnt_lo == $past(rld_lo) && flags[FLG_LOW])
        else $error("split low byte overflow mishandled");

    AST_CAPTURE_COPY: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && cap_event)
        |=> {rld_hi, rld_lo} == $past({cnt_hi, cnt_lo}) && flags[FLG_HIGH])
        else $error("capture did not copy count or set high flag");

    AST_FLAG_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
        (flags[FLG_HIGH] && !(wr_clr && w_data[FLG_HIGH]))
        |=> flags[FLG_HIGH])
        else $error("high flag cleared without a software write");

    AST_IRQ_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
        irq == (ien[FLG_HIGH] && (flags[FLG_HIGH] || (ien[FLG_LOW] && flags[FLG_LOW]))))
        else $error("interrupt level disagrees with flags and enables");

    AST_WRITE_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && do_write) |=> bvalid)
        else $error("write not answered");

endmodule

`default_nettype wire
